// File: src/flash_status_write_protect.sv
// status registers and write gating of the serial flash
// assumes a same-clock framer delivering whole commands and a datapath reporting op_done_i
`timescale 1ns/1ps
module flash_status_write_protect
  import flash_wp_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // protect pin, asynchronous
  input  wire logic        wp_pin_n_i,
  // decoded command from the framer
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic [23:0] cmd_addr_i,
  input  wire logic [15:0] cmd_data_i,
  input  wire logic        cmd_two_bytes_i,
  // array datapath and suspend sequencer
  input  wire logic        op_done_i,
  input  wire logic        erase_suspend_i,
  input  wire logic        program_suspend_i,
  input  wire logic        resume_i,
  // status bytes
  output logic [7:0]       status_low_o,
  output logic [7:0]       status_high_o,
  // command outcome
  output logic             op_start_o,
  output logic [7:0]       op_code_o,
  output logic [21:0]      op_addr_o,
  output logic             cmd_refused_o,
  output logic             quad_pins_o
);

  function automatic logic is_array_write(input logic [7:0] code);
    is_array_write = (code == CMD_PAGE_WRITE) || (code == CMD_QUAD_WRITE) ||
                     (code == CMD_SECTOR_WIPE) || (code == CMD_BLOCK32_WIPE) ||
                     (code == CMD_BLOCK64_WIPE);
  endfunction : is_array_write

  function automatic logic is_chip_wipe(input logic [7:0] code);
    is_chip_wipe = (code == CMD_CHIP_WIPE_A) || (code == CMD_CHIP_WIPE_B);
  endfunction : is_chip_wipe

  function automatic logic [21:0] span_of(input logic [7:0] code);
    case (code)
      CMD_SECTOR_WIPE:  span_of = SPAN_SECTOR;
      CMD_BLOCK32_WIPE: span_of = SPAN_BLK32;
      CMD_BLOCK64_WIPE: span_of = SPAN_BLK64;
      default:          span_of = SPAN_PAGE;
    endcase
  endfunction : span_of

  logic              wp_meta_reg;
  logic              wp_sync_reg;
  logic [4:0]        bp_reg;
  logic              lock0_reg;
  logic              lock1_reg;
  logic              cmp_reg;
  logic              qe_reg;
  logic [2:0]        lb_reg;
  logic              wel_reg;
  logic              busy_reg;
  logic              esus_reg;
  logic              psus_reg;
  logic              rst_armed_reg;
  logic [WCNT_W-1:0] wcnt_reg;
  busy_state_t       state_reg;
  busy_state_t       state_next;

  logic              prot_none;
  logic [21:0]       prot_lo;
  logic [21:0]       prot_hi;
  logic [21:0]       span;
  logic [21:0]       first;
  logic [21:0]       last;
  logic              hit;
  logic              wp_high;
  logic              status_ok;
  logic              chip_ok;
  logic              is_status_write_cmd;
  logic              is_arr;
  logic              is_chip;
  logic              write_class;
  logic              take_write;
  logic              accept_status_write_cmd;
  logic              accept_arr;
  logic              sw_reset;
  logic              guard;

  // the protect pin is asynchronous to clk_i
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wp_meta_reg <= 1'b1;
      wp_sync_reg <= 1'b1;
    end
    else if (ce_i)
    begin
      wp_meta_reg <= wp_pin_n_i;
      wp_sync_reg <= wp_meta_reg;
    end
  end

  protect_region_decode u_region (
    .bp_i   (bp_reg),
    .cmp_i  (cmp_reg),
    .none_o (prot_none),
    .lo_o   (prot_lo),
    .hi_o   (prot_hi)
  );

  always_comb
  begin
    // with quad enable set the pin carries data, so it cannot act as a protect level
    wp_high     = wp_sync_reg | qe_reg;
    guard       = ~wp_high;
    is_status_write_cmd     = cmd_code_i == CMD_STATUS_WRITE;
    is_arr      = is_array_write(cmd_code_i);
    is_chip     = is_chip_wipe(cmd_code_i);
    write_class = is_status_write_cmd | is_arr | is_chip;
    take_write  = cmd_valid_i & write_class & ~busy_reg;
    span        = span_of(cmd_code_i);
    first       = cmd_addr_i[21:0] & ~span;
    last        = first | span;
    hit         = ~prot_none & (last >= prot_lo) & (first <= prot_hi);
    case ({lock1_reg, lock0_reg})
      LOCK_SOFT: status_ok = 1'b1;
      LOCK_HW:   status_ok = wp_high;
      default:   status_ok = 1'b0;
    endcase
    chip_ok     = ((bp_reg[2:0] == 3'd0) & ~cmp_reg) |
                  ((bp_reg[2:0] == 3'd7) & cmp_reg);
    accept_status_write_cmd = take_write & is_status_write_cmd & wel_reg & status_ok;
    accept_arr  = take_write & wel_reg &
                  ((is_arr & ~hit) | (is_chip & chip_ok));
    sw_reset    = cmd_valid_i & ~busy_reg & rst_armed_reg & (cmd_code_i == CMD_RESET_GO);
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (accept_status_write_cmd)
        begin
          state_next = ST_STATUS;
        end
        else if (accept_arr)
        begin
          state_next = ST_ARRAY;
        end
      end
      ST_STATUS:
      begin
        if (wcnt_reg == '0)
        begin
          state_next = ST_IDLE;
        end
      end
      ST_ARRAY:
      begin
        if (op_done_i)
        begin
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ST_IDLE;
      busy_reg  <= 1'b0;
      wcnt_reg  <= '0;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      busy_reg  <= state_next != ST_IDLE;
      if (accept_status_write_cmd)
      begin
        wcnt_reg <= WCNT_W'(STATUS_WRITE_CYC - 2);
      end
      else if (wcnt_reg != '0)
      begin
        wcnt_reg <= wcnt_reg - 1'b1;
      end
    end
  end

  // the arm flag only survives until the very next command
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rst_armed_reg <= 1'b0;
    end
    else if (ce_i && cmd_valid_i)
    begin
      rst_armed_reg <= cmd_code_i == CMD_RESET_ARM;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wel_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (cmd_valid_i && cmd_code_i == CMD_LATCH_SET)
      begin
        wel_reg <= 1'b1;
      end
      else if (sw_reset || take_write ||
               (cmd_valid_i && cmd_code_i == CMD_LATCH_CLEAR))
      begin
        wel_reg <= 1'b0;
      end
    end
  end

  // power-up reset stands for a power cycle, so every lock mode returns to its default here
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      bp_reg    <= BP_RST;
      lock0_reg <= LOCK_RST[0];
      lock1_reg <= LOCK_RST[1];
      cmp_reg   <= CMP_RST;
      qe_reg    <= QE_RST;
      lb_reg    <= LB_RST;
    end
    else if (ce_i)
    begin
      if (accept_status_write_cmd)
      begin
        if (!guard)
        begin
          bp_reg    <= cmd_data_i[BP_LSB +: 5];
          lock0_reg <= cmd_data_i[LOCK0_BIT];
          if (cmd_two_bytes_i)
          begin
            lock1_reg <= cmd_data_i[LOCK1_BIT];
          end
        end
        if (cmd_two_bytes_i)
        begin
          cmp_reg <= cmd_data_i[CMP_BIT];
          qe_reg  <= cmd_data_i[QE_BIT];
          // lock bits are one-time: they can only be set
          lb_reg  <= lb_reg | cmd_data_i[LB_LSB +: 3];
        end
      end
      else if (sw_reset && {lock1_reg, lock0_reg} == LOCK_POWER)
      begin
        lock0_reg <= 1'b0;
        lock1_reg <= 1'b0;
      end
    end
  end

  // a suspend that lands with the clear still sets the flag
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      esus_reg <= 1'b0;
      psus_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      esus_reg <= erase_suspend_i | (esus_reg & ~resume_i & ~sw_reset);
      psus_reg <= program_suspend_i | (psus_reg & ~resume_i & ~sw_reset);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      op_start_o    <= 1'b0;
      op_code_o     <= 8'h00;
      op_addr_o     <= 22'h000000;
      cmd_refused_o <= 1'b0;
    end
    else if (ce_i)
    begin
      op_start_o    <= accept_arr;
      cmd_refused_o <= cmd_valid_i & write_class & ~accept_arr & ~accept_status_write_cmd;
      if (accept_arr)
      begin
        op_code_o <= cmd_code_i;
        op_addr_o <= cmd_addr_i[21:0];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      quad_pins_o <= 1'b0;
    end
    else if (ce_i)
    begin
      quad_pins_o <= qe_reg;
    end
  end

  assign status_low_o  = {lock0_reg, bp_reg, wel_reg, busy_reg};
  assign status_high_o = {esus_reg, cmp_reg, lb_reg, psus_reg, qe_reg, lock1_reg};

endmodule : flash_status_write_protect

// File: src/flash_wp_pkg.sv
// constants, types and command codes of the flash status and write-protect block
// assumes a 100 MHz system clock and a command framer that hands over decoded commands
//
// Overview of operation
// - status low byte is lock mode 0, block protect 4..0, write latch, busy flag.
// - status high byte is erase suspended, complement, three locks, program suspended, quad, lock 1.
// - busy flag is 1 during program, erase or status write, else 0.
// - write latch at 0 rejects status write, program and erase commands.
// - program and sector or block erase into the protected region are refused.
// - block protect field changes by status write only outside hardware protected mode.
// - chip erase runs only with protect 2..0 all 0 and complement clear, or all 1 and set.
// - complement set inverts the protected region; 000 protects all, 111 nothing.
// - lock mode 00 accepts status writes with write latch set, whatever the protect pin.
// - lock mode 01 with protect pin low and quad enable 0 refuses every status write.
// - lock mode 01 with protect pin high accepts status writes when write latch is set.
// - lock mode 10 refuses status writes until a power cycle or completed software reset.
// - lock mode 11 refuses status writes permanently; the block returns it to 00 on power-up reset.
// - lock mode 10 returns to 00 on power cycle or completed software reset.
// - quad enable 0 keeps protect and pause pins as controls, 1 makes them data lines.
// - write latch clears on power-up, software reset, disable, status write, program, erase.
// - protect pin low with quad enable 0 guards block protect field and lock mode bits against change.
// - complement clear: 000 protects nothing, 111 all, others upper, lower, top or bottom parts.
package flash_wp_pkg;

  localparam int          ADDR_W      = 22;
  localparam logic [21:0] ARRAY_LAST  = 22'h3FFFFF;
  localparam logic [21:0] LARGE_UNIT  = 22'h010000;
  localparam logic [21:0] SMALL_UNIT  = 22'h001000;
  localparam logic [21:0] SPAN_PAGE   = 22'h0000FF;
  localparam logic [21:0] SPAN_SECTOR = 22'h000FFF;
  localparam logic [21:0] SPAN_BLK32  = 22'h007FFF;
  localparam logic [21:0] SPAN_BLK64  = 22'h00FFFF;

  localparam logic [7:0] CMD_LATCH_SET    = 8'h06;
  localparam logic [7:0] CMD_LATCH_CLEAR  = 8'h04;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_PAGE_WRITE   = 8'h02;
  localparam logic [7:0] CMD_QUAD_WRITE   = 8'h32;
  localparam logic [7:0] CMD_SECTOR_WIPE  = 8'h20;
  localparam logic [7:0] CMD_BLOCK32_WIPE = 8'h52;
  localparam logic [7:0] CMD_BLOCK64_WIPE = 8'hD8;
  localparam logic [7:0] CMD_CHIP_WIPE_A  = 8'h60;
  localparam logic [7:0] CMD_CHIP_WIPE_B  = 8'hC7;
  localparam logic [7:0] CMD_RESET_ARM    = 8'h66;
  localparam logic [7:0] CMD_RESET_GO     = 8'h99;

  // low byte fields
  localparam int LOCK0_BIT = 7;
  localparam int BP_LSB    = 2;
  localparam int WEL_BIT   = 1;
  // high byte fields, as bit positions of the 16-bit write data
  localparam int ESUS_BIT  = 15;
  localparam int CMP_BIT   = 14;
  localparam int LB_LSB    = 11;
  localparam int PSUS_BIT  = 10;
  localparam int QE_BIT    = 9;
  localparam int LOCK1_BIT = 8;

  localparam logic [4:0] BP_RST    = 5'h00;
  localparam logic [2:0] LB_RST    = 3'h0;
  localparam logic       CMP_RST   = 1'b0;
  localparam logic       QE_RST    = 1'b0;
  localparam logic [1:0] LOCK_RST  = 2'h0;

  localparam int CLK_PERIOD_NS     = 10;
  localparam int STATUS_WRITE_NS   = 5000;
  localparam int STATUS_WRITE_CYC  = (STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WCNT_W            = 9;

  // lock mode as {lock 1, lock 0}
  localparam logic [1:0] LOCK_SOFT  = 2'h0;
  localparam logic [1:0] LOCK_HW    = 2'h1;
  localparam logic [1:0] LOCK_POWER = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_STATUS = 2'b01,
    ST_ARRAY  = 2'b11
  } busy_state_t;

endpackage : flash_wp_pkg

// File: src/protect_region_decode.sv
// combinational decode of block protect and complement into one protected address range
// assumes a 4 MB array; the range is contiguous in every mode, so lo/hi describe it fully
`timescale 1ns/1ps
module protect_region_decode
  import flash_wp_pkg::*;
(
  // protection setting
  input  wire logic [4:0]  bp_i,
  input  wire logic        cmp_i,
  // protected range, inclusive
  output logic             none_o,
  output logic [21:0]      lo_o,
  output logic [21:0]      hi_o
);

  logic [2:0]  code;
  logic [2:0]  shift;
  logic [21:0] size;

  always_comb
  begin
    code  = bp_i[2:0];
    shift = 3'(code - 3'd1);
    if (bp_i[4] && code >= 3'd4)
    begin
      shift = 3'd3;
    end
    size = (bp_i[4] ? SMALL_UNIT : LARGE_UNIT) << shift;
  end

  always_comb
  begin
    none_o = 1'b0;
    lo_o   = 22'h000000;
    hi_o   = ARRAY_LAST;
    if (code == 3'd0)
    begin
      none_o = ~cmp_i;
    end
    else if (code == 3'd7)
    begin
      none_o = cmp_i;
    end
    else if (!bp_i[3])
    begin
      // top region; complement keeps everything below it
      if (cmp_i)
      begin
        hi_o = 22'(ARRAY_LAST - size);
      end
      else
      begin
        lo_o = 22'(ARRAY_LAST - size + 22'd1);
      end
    end
    else
    begin
      if (cmp_i)
      begin
        lo_o = size;
      end
      else
      begin
        hi_o = 22'(size - 22'd1);
      end
    end
  end

endmodule : protect_region_decode

// File: sim/flash_wp_asserts.sv
// concurrent checks on the status and write-protect block
// sees only the top ports; bound to every instance at the foot
`timescale 1ns/1ps
module flash_wp_asserts (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       ce_i,
  // pin and command
  input wire logic       wp_pin_n_i,
  input wire logic       cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  // outcome
  input wire logic [7:0] status_low_o,
  input wire logic [7:0] status_high_o,
  input wire logic       op_start_o,
  input wire logic       cmd_refused_o,
  input wire logic       quad_pins_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic       take;
  logic       wr;
  logic       ws;
  logic [1:0] lk;
  logic       cok;
  assign take = ce_i && cmd_valid_i;
  assign wr = take && (cmd_code_i inside {8'h01, 8'h02, 8'h32, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7});
  assign ws = take && cmd_code_i == 8'h01;
  assign lk = {status_high_o[0], status_low_o[7]};
  assign cok = (status_low_o[4:2] == 3'h0 && !status_high_o[6]) || (status_low_o[4:2] == 3'h7 && status_high_o[6]);
  a_no_latch: assert property (wr && !status_low_o[1] |=> cmd_refused_o && !op_start_o)
    else $error("write taken without latch");
  a_busy_block: assert property (wr && status_low_o[0] |=> cmd_refused_o && !op_start_o)
    else $error("write taken while busy");
  a_start_state: assert property (op_start_o |-> status_low_o[0] && !status_low_o[1])
    else $error("start without busy or with latch");
  a_chip_guard: assert property (take && (cmd_code_i inside {8'h60, 8'hC7}) && !cok && !status_low_o[0]
    |=> cmd_refused_o && !op_start_o)
    else $error("chip erase outside allowed setting");
  a_status_busy: assert property ($rose(status_low_o[0]) && !op_start_o |-> status_low_o[0] [*8])
    else $error("status write busy too short");
  a_lock_power: assert property (ws && lk == 2'h2 |=> cmd_refused_o && $stable(status_low_o[7:2]))
    else $error("status write in power lock");
  // both suspend flags are left out: a suspend pulse may legally land in the same cycle
  a_lock_otp: assert property (ws && lk == 2'h3 |=> cmd_refused_o && $stable(status_high_o[6:3]) && $stable(status_high_o[1:0]))
    else $error("status write in permanent lock");
  // with quad enable set the pin is a data line and no longer locks the status write
  a_pin_lock: assert property (ws && lk == 2'h1 && !status_high_o[1] && !wp_pin_n_i && !$past(wp_pin_n_i) && !$past(wp_pin_n_i, 2)
    && !$past(wp_pin_n_i, 3) |=> cmd_refused_o)
    else $error("status write with pin low");
  a_quad_pins: assert property ($stable(status_high_o[1]) |-> quad_pins_o == status_high_o[1])
    else $error("quad pin role differs from enable");
endmodule : flash_wp_asserts

bind flash_status_write_protect flash_wp_asserts chk_i (.clk_i, .rst_n_i, .ce_i, .wp_pin_n_i, .cmd_valid_i,
  .cmd_code_i, .status_low_o, .status_high_o, .op_start_o, .cmd_refused_o, .quad_pins_o);

// File: sim/flash_host_model.sv
// host side: hands decoded commands over and plays the array datapath
// assumes the block samples on the rising edge; all changes on the falling edge
`timescale 1ns/1ps
module flash_host_model (
  // clock and datapath trigger
  input  wire logic        clk_i,
  input  wire logic        op_start_i,
  // decoded command
  output logic             cmd_valid_o,
  output logic [7:0]       cmd_code_o,
  output logic [23:0]      cmd_addr_o,
  output logic [15:0]      cmd_data_o,
  output logic             cmd_two_bytes_o,
  // datapath and suspend sequencer
  output logic             op_done_o,
  output logic             erase_suspend_o,
  output logic             program_suspend_o,
  output logic             resume_o
);
  int lat = 1;
  int cnt = 0;
  initial
  begin
    {cmd_valid_o, cmd_code_o, cmd_addr_o, cmd_data_o, cmd_two_bytes_o} = '0;
    {op_done_o, erase_suspend_o, program_suspend_o, resume_o} = 4'h0;
  end
  // quad enable may be set here: protect and pause pins are not tied to a rail
  task send(input logic [7:0] c, input logic [23:0] a, input logic [15:0] d, input logic t);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o = c;
    cmd_addr_o = a;
    cmd_data_o = d;
    cmd_two_bytes_o = t;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    // released qualifiers must not keep showing the last value
    cmd_code_o = ~c;
    cmd_addr_o = ~a;
    cmd_data_o = ~d;
  endtask : send
  task pulse(input int k);
    @(negedge clk_i);
    erase_suspend_o = (k == 0);
    program_suspend_o = (k == 1);
    resume_o = (k == 2);
    @(negedge clk_i);
    {erase_suspend_o, program_suspend_o, resume_o} = 3'h0;
  endtask : pulse
  // array operation ends lat cycles after start; slow settings let commands land mid-operation
  always @(negedge clk_i)
  begin
    op_done_o <= 1'b0;
    if (op_start_i)
      cnt <= lat;
    else if (cnt == 1)
    begin
      cnt <= 0;
      op_done_o <= 1'b1;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule : flash_host_model

// File: sim/testbench.sv
// self-checking bench for the status and write-protect block
// assumes the host model drives commands; results noted in a queue, checked by a monitor
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic r; logic [7:0] c; logic [21:0] a;} note_t;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        wp_pin_n_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        cmd_valid_i, cmd_two_bytes_i, op_done_i, erase_suspend_i, program_suspend_i, resume_i;
  logic [7:0]  cmd_code_i, status_low_o, status_high_o, op_code_o;
  logic [23:0] cmd_addr_i;
  logic [15:0] cmd_data_i;
  logic [21:0] op_addr_o;
  logic        op_start_o, cmd_refused_o, quad_pins_o;
  logic [31:0] rnd = 32'h7B05;
  logic [7:0]  codes [5] = '{8'h02, 8'h32, 8'h20, 8'h52, 8'hD8};
  note_t       q[$];
  note_t       nt;
  int          n_fail = 0;
  int          compares = 0;
  int          cyc = 0;

  flash_status_write_protect dut (.clk_i, .rst_n_i, .ce_i, .wp_pin_n_i, .cmd_valid_i, .cmd_code_i,
    .cmd_addr_i, .cmd_data_i, .cmd_two_bytes_i, .op_done_i, .erase_suspend_i, .program_suspend_i, .resume_i,
    .status_low_o, .status_high_o, .op_start_o, .op_code_o, .op_addr_o, .cmd_refused_o, .quad_pins_o);
  flash_host_model host (.clk_i, .op_start_i(op_start_o), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
    .cmd_addr_o(cmd_addr_i), .cmd_data_o(cmd_data_i), .cmd_two_bytes_o(cmd_two_bytes_i), .op_done_o(op_done_i),
    .erase_suspend_o(erase_suspend_i), .program_suspend_o(program_suspend_i), .resume_o(resume_i));

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task fail(input string m);
    $display("wrong value at %0t: %s", $time, m);
    n_fail++;
  endtask : fail
  task chk(input logic [15:0] e, input logic qk = 1'b1);
    compares++;
    if ({status_high_o, status_low_o} !== e || (qk && quad_pins_o !== e[9]))
      fail("status bytes");
  endtask : chk
  task ev(input note_t n);
    compares++;
    if (n.r ? (cmd_refused_o !== 1'b1 || op_start_o !== 1'b0)
            : (op_start_o !== 1'b1 || op_code_o !== n.c || op_addr_o !== n.a))
      fail("command outcome");
  endtask : ev
  // x: 0 no outcome, 1 refused, 2 started
  task cmd(input int x, input logic [7:0] c, input logic [21:0] a = 22'h0, input logic [15:0] d = 16'h0,
           input logic t = 1'b1);
    if (x != 0)
      q.push_back('{x == 1, c, a});
    host.send(c, {2'h0, a}, d, t);
  endtask : cmd
  task idle;
    repeat (700)
      if (status_low_o[0] !== 1'b0)
        @(negedge clk_i);
    compares++;
    if (status_low_o[0] !== 1'b0)
      fail("busy flag stuck");
  endtask : idle
  task wsr(input logic [15:0] d, input logic [15:0] e, input logic ok, input logic t = 1'b1);
    cmd(0, 8'h06);
    cmd(ok ? 0 : 1, 8'h01, 22'h0, d, t);
    chk(ok ? (e | 16'h0001) : e, 1'b0);
    idle();
    chk(e);
  endtask : wsr
  task wp(input logic v);
    wp_pin_n_i = v;
    repeat (3) @(negedge clk_i);
  endtask : wp
  task results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  always @(negedge clk_i)
    if (op_start_o === 1'b1 || cmd_refused_o === 1'b1)
    begin
      if (q.size() == 0)
        fail("unexpected outcome");
      else
      begin
        nt = q.pop_front();
        ev(nt);
      end
    end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      results();
    end
  end

  initial
  begin
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    chk(16'h0000);
    cmd(1, 8'h02);
    cmd(0, 8'h06);
    chk(16'h0002);
    cmd(0, 8'h04);
    chk(16'h0000);
    // with the enable low a latch-set command must leave no trace
    ce_i = 1'b0;
    cmd(0, 8'h06);
    chk(16'h0000);
    ce_i = 1'b1;
    $display("test latch done");
    wsr(16'h0004, 16'h0004, 1'b1, 1'b0);
    cmd(0, 8'h06);
    cmd(1, 8'h20, 22'h3F0000);
    chk(16'h0004);
    host.lat = 40;
    cmd(0, 8'h06);
    cmd(2, 8'h20, 22'h3EF000);
    chk(16'h0005);
    cmd(0, 8'h06);
    cmd(1, 8'hD8, 22'h000000);
    chk(16'h0007);
    idle();
    cmd(1, 8'h60);
    host.lat = 1;
    for (int i = 0; i < 10; i++)
    begin
      rnd = lfsr(rnd);
      cmd(0, 8'h06);
      cmd(rnd[0] || rnd[21:16] == 6'h3F ? 1 : 2, codes[i % 5], {rnd[0] ? 6'h3F : rnd[21:16], 16'h0});
      idle();
    end
    $display("test protect done");
    wsr(16'h401C, 16'h401C, 1'b1);
    cmd(0, 8'h06);
    cmd(2, 8'h60);
    idle();
    cmd(0, 8'h06);
    cmd(2, 8'hC7);
    idle();
    wsr(16'h4000, 16'h4000, 1'b1);
    cmd(0, 8'h06);
    cmd(1, 8'h02, 22'h3FF000);
    cmd(0, 8'h06);
    cmd(1, 8'hC7);
    wsr(16'h4044, 16'h4044, 1'b1);
    cmd(0, 8'h06);
    cmd(2, 8'h02, 22'h3FF000);
    idle();
    cmd(0, 8'h06);
    cmd(1, 8'h02, 22'h3FEF00);
    $display("test complement done");
    wsr(16'h0200, 16'h0200, 1'b1);
    wsr(16'h0000, 16'h0000, 1'b1);
    wsr(16'h0080, 16'h0080, 1'b1);
    wp(1'b0);
    wsr(16'h0084, 16'h0080, 1'b0);
    wp(1'b1);
    wsr(16'h0084, 16'h0084, 1'b1);
    wsr(16'h0100, 16'h0100, 1'b1);
    wsr(16'h0004, 16'h0100, 1'b0);
    cmd(0, 8'h66);
    cmd(0, 8'h99);
    chk(16'h0000);
    wp(1'b0);
    wsr(16'h000C, 16'h0000, 1'b1);
    wp(1'b1);
    $display("test lock done");
    host.pulse(0);
    chk(16'h8000);
    host.pulse(1);
    chk(16'h8400);
    host.pulse(2);
    chk(16'h0000);
    wsr(16'h0180, 16'h0180, 1'b1);
    wsr(16'h0004, 16'h0180, 1'b0);
    rst_n_i = 1'b0;
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    chk(16'h0000);
    $display("test power cycle done");
    compares++;
    if (q.size() != 0)
      fail("outcome missing");
    results();
  end
endmodule : testbench
